// >>> core/iwt_top.sv
// Interval timer and watchdog with stop-release wait, reached over an Avalon-MM slave.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "iwt_map.svh"

module iwt_top
  import iwt_pkg::*;
#(
  // Prescaler select used for the wait after device reset.
  parameter logic [2:0] RST_WAIT_SEL = `IWT_SEL_DIV7
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Avalon-MM slave
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Standby control from the CPU core
  input wire logic STOP_MODE,
  // Results
  output logic IRQ,
  output logic WDT_RESET,
  output logic CPU_HOLD
);

  iwt_regs_s r;
  iwt_regs_s n;
  logic tick;
  logic pre_clr;
  logic [2:0] pre_sel;
  logic ovf;
  logic in_wait;
  logic access;
  logic wr_en;
  logic [31:0] rd_mux;

  localparam iwt_regs_s REGS_RESET = '{
    st: IWT_RESET_WAIT,
    interval_count: `IWT_COUNT_RESET,
    interval_select: `IWT_MODE_RESET,
    watchdog_arm_flag: 1'b0,
    status: `IWT_STATUS_RESET,
    mask: `IWT_MASK_RESET,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    wdt_rst: 1'b0,
    hold: 1'b1,
    irq: 1'b0
  };

  // The reset wait runs on a fixed tap; all later intervals follow the mode register.
  assign pre_sel = (r.st == IWT_RESET_WAIT) ? RST_WAIT_SEL : r.interval_select;

  // Leaving stop mode restarts prescaler and count so the wait is a full interval.
  assign pre_clr = (r.st == IWT_STOPPED) && !STOP_MODE;

  iwt_prescaler u_prescaler (
    .REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST),
    .CLR(pre_clr),
    .SEL(pre_sel),
    .TICK(tick)
  );

  assign ovf = tick && (r.interval_count == `IWT_COUNT_MAX);
  assign in_wait = (r.st == IWT_RESET_WAIT) || (r.st == IWT_STOP_WAIT);

  // One wait cycle per access keeps read data coming from a flip-flop.
  assign access = (AVS_READ || AVS_WRITE) && !r.ack;
  assign wr_en = AVS_WRITE && r.ack && AVS_BYTEENABLE[0];

  always_comb
  begin
    case (AVS_ADDRESS)
      `IWT_ADDR_MODE:
      begin
        rd_mux = {29'h0000_0000, r.interval_select};
      end
      `IWT_ADDR_COUNT:
      begin
        rd_mux = {24'h00_0000, r.interval_count};
      end
      `IWT_ADDR_ARM:
      begin
        rd_mux = {31'h0000_0000, r.watchdog_arm_flag};
      end
      `IWT_ADDR_STATUS:
      begin
        rd_mux = {30'h0000_0000, r.status};
      end
      `IWT_ADDR_MASK:
      begin
        rd_mux = {30'h0000_0000, r.mask};
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb
  begin
    n = r;
    n.wdt_rst = 1'b0;

    // Bus handshake and read capture.
    n.ack = access;
    if (access && AVS_READ)
    begin
      n.rdata = rd_mux;
    end

    // Free-running count; the natural 8-bit wrap takes it from maximum to zero.
    if (tick)
    begin
      n.interval_count = r.interval_count + 8'h01;
    end

    // Standby sequencing.
    case (r.st)
      IWT_RESET_WAIT:
      begin
        if (ovf)
        begin
          n.st = IWT_RUN;
        end
      end
      IWT_RUN:
      begin
        if (STOP_MODE)
        begin
          n.st = IWT_STOPPED;
        end
      end
      IWT_STOPPED:
      begin
        if (!STOP_MODE)
        begin
          n.st = IWT_STOP_WAIT;
          n.interval_count = `IWT_COUNT_RESET;
        end
      end
      IWT_STOP_WAIT:
      begin
        if (ovf)
        begin
          n.st = IWT_RUN;
        end
      end
      default:
      begin
        n.st = IWT_RUN;
      end
    endcase

    // Register writes; these clears come before the event sets below.
    if (wr_en)
    begin
      case (AVS_ADDRESS)
        `IWT_ADDR_MODE:
        begin
          n.interval_select = AVS_WRITEDATA[2:0];
          if (AVS_WRITEDATA[`IWT_MODE_RESTART_BIT])
          begin
            // The command is consumed here, so the bit is never stored.
            n.interval_count = `IWT_COUNT_RESET;
            n.status[`IWT_ST_INTERVAL_BIT] = 1'b0;
          end
        end
        `IWT_ADDR_ARM:
        begin
          if (AVS_WRITEDATA[`IWT_ARM_BIT])
          begin
            n.watchdog_arm_flag = 1'b1;
          end
        end
        `IWT_ADDR_STATUS:
        begin
          n.status = r.status & ~AVS_WRITEDATA[1:0];
        end
        `IWT_ADDR_MASK:
        begin
          n.mask = AVS_WRITEDATA[1:0];
        end
        default:
        begin
          n.mask = r.mask;
        end
      endcase
    end

    // Overflow events; a set in the same cycle as a clear wins.
    if (ovf && !in_wait)
    begin
      if (r.watchdog_arm_flag)
      begin
        n.wdt_rst = 1'b1;
      end
      else
      begin
        n.status[`IWT_ST_INTERVAL_BIT] = 1'b1;
      end
    end
    if (ovf && (r.st == IWT_STOP_WAIT))
    begin
      // Reset stays quiet here even when armed.
      n.status[`IWT_ST_WAKE_BIT] = 1'b1;
    end

    n.hold = (n.st != IWT_RUN);
    n.irq = |(n.status & n.mask);
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      r <= REGS_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  assign AVS_WAITREQUEST = !r.ack;
  assign AVS_READDATA = r.rdata;
  assign IRQ = r.irq;
  assign WDT_RESET = r.wdt_rst;
  assign CPU_HOLD = r.hold;

endmodule

// >>> core/iwt_map.svh
// Register offsets, field positions, reset values and divider settings of the interval watchdog timer.
`ifndef IWT_MAP_SVH
`define IWT_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IWT_IDX_MODE 16'h0F85
`define IWT_IDX_COUNT 16'h0F86
`define IWT_IDX_ARM 16'h0F87
`define IWT_IDX_STATUS 16'h0F88
`define IWT_IDX_MASK 16'h0F89
`define IWT_ADDR_MODE 16'h3E14
`define IWT_ADDR_COUNT 16'h3E18
`define IWT_ADDR_ARM 16'h3E1C
`define IWT_ADDR_STATUS 16'h3E20
`define IWT_ADDR_MASK 16'h3E24

// Field positions.
`define IWT_MODE_RESTART_BIT 3
`define IWT_ARM_BIT 0
`define IWT_ST_INTERVAL_BIT 0
`define IWT_ST_WAKE_BIT 1

// Reset values.
`define IWT_MODE_RESET 3'h0
`define IWT_COUNT_RESET 8'h00
`define IWT_STATUS_RESET 2'h0
`define IWT_MASK_RESET 2'h0

// Select codes and the prescaler tap width that each one picks.
`define IWT_SEL_DIV12 3'h0
`define IWT_SEL_DIV9 3'h3
`define IWT_SEL_DIV7 3'h5
`define IWT_SEL_DIV5 3'h7
`define IWT_TAP_DIV12 12'hFFF
`define IWT_TAP_DIV9 12'h1FF
`define IWT_TAP_DIV7 12'h07F
`define IWT_TAP_DIV5 12'h01F

`define IWT_COUNT_MAX 8'hFF
`define IWT_PRE_RESET 12'h000

`endif

// >>> core/iwt_pkg.sv
// Types shared by the interval watchdog timer modules.
package iwt_pkg;

  typedef enum logic [1:0] {
    IWT_RESET_WAIT = 2'b00,
    IWT_RUN = 2'b01,
    IWT_STOPPED = 2'b10,
    IWT_STOP_WAIT = 2'b11
  } iwt_state_e;

  typedef struct packed {
    iwt_state_e st;
    logic [7:0] interval_count;
    logic [2:0] interval_select;
    logic watchdog_arm_flag;
    logic [1:0] status;
    logic [1:0] mask;
    logic ack;
    logic [31:0] rdata;
    logic wdt_rst;
    logic hold;
    logic irq;
  } iwt_regs_s;

  typedef struct packed {
    logic [11:0] div;
  } iwt_pre_s;

endpackage

// >>> core/iwt_prescaler.sv
// System clock prescaler that produces the interval counter tick for the selected division.
`timescale 1ns/1ps
`include "iwt_map.svh"

module iwt_prescaler
  import iwt_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Control
  input wire logic CLR,
  input wire logic [2:0] SEL,
  // Tick out
  output logic TICK
);

  iwt_pre_s r;
  iwt_pre_s n;
  logic [11:0] tap;

  // Prohibited codes fall back to the slowest tap so the count never stalls.
  always_comb
  begin
    case (SEL)
      `IWT_SEL_DIV9: tap = `IWT_TAP_DIV9;
      `IWT_SEL_DIV7: tap = `IWT_TAP_DIV7;
      `IWT_SEL_DIV5: tap = `IWT_TAP_DIV5;
      default: tap = `IWT_TAP_DIV12;
    endcase
  end

  always_comb
  begin
    n = r;
    if (CLR)
    begin
      n.div = `IWT_PRE_RESET;
    end
    else
    begin
      n.div = r.div + 12'h001;
    end
  end

  assign TICK = !CLR && ((r.div & tap) == tap);

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      r <= '{div: `IWT_PRE_RESET};
    end
    else
    begin
      r <= n;
    end
  end

endmodule

// >>> test/iwt_top_properties.sv
// Port-level assertions for the interval watchdog timer.
`timescale 1ns/1ps
`include "iwt_map.svh"
module iwt_properties
  import iwt_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Register bus
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Standby and results
  input wire logic STOP_MODE,
  input wire logic IRQ,
  input wire logic WDT_RESET,
  input wire logic CPU_HOLD
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  wire rd_done = AVS_READ && !AVS_WAITREQUEST;
  wire mask_off = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == `IWT_ADDR_MASK
    && AVS_WRITEDATA[1:0] == 2'h0;
  property p_one_wait;
    $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait");
  property p_short_answer;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_short_answer: assert property (p_short_answer) else $error("bus answer too long");
  property p_restart_reads0;
    rd_done && AVS_ADDRESS == `IWT_ADDR_MODE |-> AVS_READDATA[31:3] == 29'h0;
  endproperty
  a_restart_reads0: assert property (p_restart_reads0) else $error("restart bit read back");
  property p_count_width;
    rd_done && AVS_ADDRESS == `IWT_ADDR_COUNT |-> AVS_READDATA[31:8] == 24'h0;
  endproperty
  a_count_width: assert property (p_count_width) else $error("count wider than 8 bits");
  property p_wdt_pulse;
    WDT_RESET |=> !WDT_RESET;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog reset not a pulse");
  property p_no_wait_reset;
    WDT_RESET |-> !$past(CPU_HOLD);
  endproperty
  a_no_wait_reset: assert property (p_no_wait_reset) else $error("reset during wait");
  property p_stop_hold;
    STOP_MODE && !CPU_HOLD |-> ##[1:2] CPU_HOLD;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("cpu not held in stop");
  property p_mask_quiet;
    mask_off |-> ##2 !IRQ;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("irq while masked");
endmodule

bind iwt_top iwt_properties iwt_properties_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .STOP_MODE(STOP_MODE), .IRQ(IRQ), .WDT_RESET(WDT_RESET), .CPU_HOLD(CPU_HOLD));

// >>> test/test_interval_watchdog_timer.sv
// Self-checking bench for the interval watchdog timer.
`timescale 1ns/1ps
`include "iwt_map.svh"
module test_interval_watchdog_timer
  import iwt_pkg::*;
;
  logic REF_CLK = 0, SYS_RST = 1, AVS_READ = 0, AVS_WRITE = 0, STOP_MODE = 0;
  logic [15:0] AVS_ADDRESS = '0;
  logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, q;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic AVS_WAITREQUEST, IRQ, WDT_RESET, CPU_HOLD;
  int n_fail = 0, comparisons = 0, n_wdt = 0, t, d;
  // The last entry is a prohibited code, which must count at the slowest rate.
  int ks[5] = '{12, 9, 7, 5, 12};
  logic [2:0] sels[5] = '{3'h0, 3'h3, 3'h5, 3'h7, 3'h2};
  always #20 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (WDT_RESET === 1'b1) n_wdt++;
  // The short reset wait, 256 ticks of 32 cycles, keeps the first wait under its 9000-cycle limit.
  iwt_top #(.RST_WAIT_SEL(3'h7)) iwt_top_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .STOP_MODE(STOP_MODE), .IRQ(IRQ), .WDT_RESET(WDT_RESET), .CPU_HOLD(CPU_HOLD));
  task conclude;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task hang;
    n_fail++;
    $display("BAD wait exp done got none");
    conclude;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Count values may move by one between capture and read, so they are checked within a range.
  task chkr(input string s, input int lo, input int hi, input logic [31:0] g);
    comparisons++;
    if ($isunknown(g) || g < lo || g > hi)
    begin
      n_fail++;
      $display("BAD %s exp %0d..%0d got %0d", s, lo, hi, g);
    end
  endtask
  task bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
    int i;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    for (i = 0; i < 20; i++)
    begin
      @(posedge REF_CLK);
      if (AVS_WAITREQUEST === 1'b0)
        break;
    end
    if (i == 20)
      hang;
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task wt(input int k, input int lim);
    t = 0;
    while (!(k == 0 ? CPU_HOLD === 1'b0 : k == 1 ? IRQ === 1'b1 : n_wdt > 0))
    begin
      @(posedge REF_CLK);
      t++;
      if (t > lim)
        hang;
    end
  endtask
  initial
  begin
    void'($urandom(8619));
    repeat (8) @(posedge REF_CLK);
    chk("hold", 1, CPU_HOLD);
    SYS_RST <= 1'b0;
    wt(0, 9000);
    chkr("rstwait", 8180, 8200, t);
    bus(0, `IWT_ADDR_MODE, 0);
    chk("mode", 0, q);
    bus(0, `IWT_ADDR_ARM, 0);
    chk("arm", 0, q);
    bus(0, 16'h0000, 0);
    chk("unmapped", 0, q);
    for (int j = 0; j < 5; j++)
    begin
      d = (3 << ks[j]) + (1 << (ks[j] - 1));
      bus(1, `IWT_ADDR_MODE, {$urandom} << 4 | 32'h8 | sels[j]);
      bus(1, `IWT_ADDR_COUNT, $urandom);
      repeat (d) @(posedge REF_CLK);
      bus(0, `IWT_ADDR_COUNT, 0);
      chkr("count", ((d + 5) >> ks[j]) - 1, ((d + 5) >> ks[j]) + 1, q);
      bus(0, `IWT_ADDR_COUNT, 0);
      chkr("count2", ((d + 5) >> ks[j]) - 1, ((d + 8) >> ks[j]) + 1, q);
      bus(0, `IWT_ADDR_MODE, 0);
      chk("mode", sels[j], q);
    end
    bus(1, `IWT_ADDR_MASK, 1);
    bus(1, `IWT_ADDR_MODE, 32'hF);
    n_wdt = 0;
    wt(1, 8300);
    chkr("irq", 8150, 8200, t);
    bus(1, `IWT_ADDR_MASK, 0);
    chk("masked", 0, IRQ);
    bus(0, `IWT_ADDR_STATUS, 0);
    chk("status", 1, q);
    bus(1, `IWT_ADDR_MODE, 32'hF);
    bus(0, `IWT_ADDR_STATUS, 0);
    chk("status", 0, q);
    chk("wdt", 0, n_wdt);
    AVS_BYTEENABLE <= 4'hE;
    bus(1, `IWT_ADDR_ARM, 1);
    AVS_BYTEENABLE <= 4'hF;
    bus(0, `IWT_ADDR_ARM, 0);
    chk("arm_lane", 0, q);
    bus(1, `IWT_ADDR_ARM, 1);
    bus(1, `IWT_ADDR_ARM, 0);
    bus(0, `IWT_ADDR_ARM, 0);
    chk("arm", 1, q);
    repeat (3)
    begin
      repeat (6000) @(posedge REF_CLK);
      bus(1, `IWT_ADDR_MODE, 32'hF);
    end
    chk("wdt", 0, n_wdt);
    wt(2, 8300);
    chkr("wdt", 8150, 8200, t);
    bus(0, `IWT_ADDR_STATUS, 0);
    chk("status", 0, q);
    bus(1, `IWT_ADDR_MODE, 32'hF);
    n_wdt = 0;
    STOP_MODE <= 1'b1;
    repeat (5 + $urandom % 20) @(posedge REF_CLK);
    chk("hold", 1, CPU_HOLD);
    STOP_MODE <= 1'b0;
    wt(0, 8300);
    chkr("stopwait", 8180, 8200, t);
    chk("wdt", 0, n_wdt);
    bus(0, `IWT_ADDR_STATUS, 0);
    chk("status", 2, q);
    conclude;
  end
endmodule
